// ==== hw/gpio_cfg.svh ====
/*
 * Register offsets, field positions, reset values and widths of the GPIO block.
 * Assumes inclusion by bare name from the gpio_ports module.
 */
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define WIDE_W          8
`define DRIVE_W         6
`define AUX_W           5
`define WIDE_RST        8'hff
`define DRIVE_RST       8'h3d
`define AUX_RST         8'h1f

`define OFF_WIDE_A_OUT  8'h00
`define OFF_WIDE_B_OUT  8'h04
`define OFF_DRIVE_OUT   8'h08
`define OFF_AUX_OUT     8'h0c
`define OFF_WIDE_A_PU   8'h10
`define OFF_WIDE_B_PU   8'h14
`define OFF_DRIVE_MODE  8'h18
`define OFF_AUX_MODE    8'h1c
`define OFF_WIDE_A_IN   8'h20
`define OFF_WIDE_B_IN   8'h24
`define OFF_DRIVE_IN    8'h28
`define OFF_AUX_IN      8'h2c
`define OFF_IRQ_EN      8'h30

`define PU_RST          8'h00
`define MODE_RST        12'h000
`define IRQ_EN_A_BIT    0
`define IRQ_EN_B_BIT    1

`endif

// ==== hw/gpio_pkg.sv ====
/*
 * Types shared by the GPIO block.
 * Assumes gpio_cfg.svh is on the include path.
 */
package gpio_pkg;
	// Per-pin mode of the drive and auxiliary ports.
	typedef enum logic [1:0] {
		MODE_INPUT      = 2'b00,
		MODE_OPEN_DRAIN = 2'b01,
		MODE_PUSH_PULL  = 2'b10
	} pin_mode_t;
	typedef logic [7:0] reg8_t;
endpackage

// ==== hw/pin_sync_if.sv ====
/*
 * Carrier between the top and the input synchroniser.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int W = 27);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport top (output raw, input synced);
	modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ==== hw/pin_sync.sv ====
/*
 * Two-stage synchroniser for all pin inputs.
 * Assumes pins are asynchronous to aclk.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int W = 27
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	pin_sync_if.sync  s
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage.
	// Idle pins read high, so both stages reset high and no false falling edge follows reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= s.raw;
			sync_q <= meta_q;
		end
	end

	assign s.synced = sync_q;
endmodule // pin_sync
`default_nettype wire

// ==== hw/gpio_ports.sv ====
/*
 * GPIO block with two wide ports, a drive port and an auxiliary port behind AXI4-Lite.
 * Assumes one 25 MHz clock, synchronous active-low reset, and a bench that resolves pins.
 */
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
// Operation
// - Port latches hold written value until reset
// - Widths eight, eight, six and five bits
// - Wide port latches reset to all ones
// - Drive port latch resets to 00111101
// - Auxiliary port latch resets to 00011111
// - Wide port pins feed two shared interrupts
// - Per-pin pull-up enables on wide ports
// - Drive, aux pins: input, open-drain, push-pull
`timescale 1ns/1ns
`default_nettype none
`include "gpio_cfg.svh"
module gpio_ports
	import gpio_pkg::*;
#(
	parameter int WA = `WIDE_W,
	parameter int WB = `WIDE_W,
	parameter int WC = `DRIVE_W,
	parameter int WD = `AUX_W
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output var  logic          s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output var  logic          s_axi_wready,
	output var  logic [1:0]    s_axi_bresp,
	output var  logic          s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output var  logic          s_axi_arready,
	output var  logic [31:0]   s_axi_rdata,
	output var  logic [1:0]    s_axi_rresp,
	output var  logic          s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic [WA-1:0] first_wide_port_i,
	output var  logic [WA-1:0] first_wide_port_o,
	output var  logic [WA-1:0] first_wide_port_oe,
	output var  logic [WA-1:0] first_wide_port_pu,
	input  wire logic [WB-1:0] second_wide_port_i,
	output var  logic [WB-1:0] second_wide_port_o,
	output var  logic [WB-1:0] second_wide_port_oe,
	output var  logic [WB-1:0] second_wide_port_pu,
	input  wire logic [WC-1:0] drive_port_i,
	output var  logic [WC-1:0] drive_port_o,
	output var  logic [WC-1:0] drive_port_oe,
	input  wire logic [WD-1:0] auxiliary_port_i,
	output var  logic [WD-1:0] auxiliary_port_o,
	output var  logic [WD-1:0] auxiliary_port_oe,
	output var  logic          first_port_irq,
	output var  logic          second_port_irq
);
	localparam int WT = WA + WB + WC + WD;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser.

	pin_sync_if #(.W(WT)) sif ();
	assign sif.raw = {auxiliary_port_i, drive_port_i, second_wide_port_i, first_wide_port_i};
	pin_sync #(.W(WT)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.s       (sif)
	);
	wire logic [WA-1:0] a_in = sif.synced[WA-1:0];
	wire logic [WB-1:0] b_in = sif.synced[WA+WB-1:WA];
	wire logic [WC-1:0] c_in = sif.synced[WA+WB+WC-1:WA+WB];
	wire logic [WD-1:0] d_in = sif.synced[WT-1:WA+WB+WC];

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	reg8_t        a_out_q, b_out_q, c_out_q, d_out_q;
	reg8_t        a_pu_q, b_pu_q;
	logic [11:0]  c_mode_q;
	logic [9:0]   d_mode_q;
	logic [1:0]   irq_en_q;
	logic [WA-1:0] a_prev_q;
	logic [WB-1:0] b_prev_q;

	// AXI write side: address and data may arrive in either order.
	logic        aw_held_q, w_held_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	wire  logic  aw_take  = s_axi_awvalid & s_axi_awready;
	wire  logic  w_take   = s_axi_wvalid & s_axi_wready;
	wire  logic  wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
	wire  logic  wr_lane0 = w_strb_q[0];
	wire  logic  wr_lane1 = w_strb_q[1];
	wire  logic  wr_hit_a = wr_fire & wr_lane0 & (aw_addr_q == `OFF_WIDE_A_OUT);
	wire  logic  wr_hit_b = wr_fire & wr_lane0 & (aw_addr_q == `OFF_WIDE_B_OUT);
	wire  logic  wr_hit_c = wr_fire & wr_lane0 & (aw_addr_q == `OFF_DRIVE_OUT);
	wire  logic  wr_hit_d = wr_fire & wr_lane0 & (aw_addr_q == `OFF_AUX_OUT);
	wire  logic  wr_hit_pa = wr_fire & wr_lane0 & (aw_addr_q == `OFF_WIDE_A_PU);
	wire  logic  wr_hit_pb = wr_fire & wr_lane0 & (aw_addr_q == `OFF_WIDE_B_PU);
	wire  logic  wr_cm    = wr_fire & (aw_addr_q == `OFF_DRIVE_MODE);
	wire  logic  wr_dm    = wr_fire & (aw_addr_q == `OFF_AUX_MODE);
	wire  logic  wr_ie    = wr_fire & wr_lane0 & (aw_addr_q == `OFF_IRQ_EN);
	wire  logic  wr_known = (aw_addr_q <= `OFF_DRIVE_MODE + 8'h04) |
	                        (aw_addr_q == `OFF_IRQ_EN);
	wire  logic  wr_ro    = (aw_addr_q >= `OFF_WIDE_A_IN) & (aw_addr_q <= `OFF_AUX_IN);
	wire  logic  wr_ok    = wr_known & ~wr_ro & (aw_addr_q[1:0] == 2'h0);

	// Write channel handshakes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held_q & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_out_q <= `WIDE_RST;
			b_out_q <= `WIDE_RST;
			c_out_q <= `DRIVE_RST;
			d_out_q <= `AUX_RST;
		end else begin
			if (wr_hit_a) a_out_q <= w_data_q[7:0];
			if (wr_hit_b) b_out_q <= w_data_q[7:0];
			if (wr_hit_c) c_out_q <= w_data_q[7:0];
			if (wr_hit_d) d_out_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_pu_q   <= `PU_RST;
			b_pu_q   <= `PU_RST;
			c_mode_q <= `MODE_RST;
			d_mode_q <= 10'h000;
			irq_en_q <= 2'h0;
		end else begin
			if (wr_hit_pa) a_pu_q <= w_data_q[7:0];
			if (wr_hit_pb) b_pu_q <= w_data_q[7:0];
			if (wr_cm & wr_lane0) c_mode_q[7:0] <= w_data_q[7:0];
			if (wr_cm & wr_lane1) c_mode_q[11:8] <= w_data_q[11:8];
			if (wr_dm & wr_lane0) d_mode_q[7:0] <= w_data_q[7:0];
			if (wr_dm & wr_lane1) d_mode_q[9:8] <= w_data_q[9:8];
			if (wr_ie) irq_en_q <= w_data_q[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read side.

	logic [31:0] rd_mux;
	logic        rd_ok;
	wire  logic  ar_take = s_axi_arvalid & s_axi_arready;

	// Read address decode.
	always_comb begin
		rd_ok  = (s_axi_araddr[1:0] == 2'h0);
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`OFF_WIDE_A_OUT: rd_mux[7:0] = a_out_q;
			`OFF_WIDE_B_OUT: rd_mux[7:0] = b_out_q;
			`OFF_DRIVE_OUT:  rd_mux[WC-1:0] = c_out_q[WC-1:0];
			`OFF_AUX_OUT:    rd_mux[WD-1:0] = d_out_q[WD-1:0];
			`OFF_WIDE_A_PU:  rd_mux[7:0] = a_pu_q;
			`OFF_WIDE_B_PU:  rd_mux[7:0] = b_pu_q;
			`OFF_DRIVE_MODE: rd_mux[11:0] = c_mode_q;
			`OFF_AUX_MODE:   rd_mux[9:0] = d_mode_q;
			`OFF_WIDE_A_IN:  rd_mux[WA-1:0] = a_in;
			`OFF_WIDE_B_IN:  rd_mux[WB-1:0] = b_in;
			`OFF_DRIVE_IN:   rd_mux[WC-1:0] = c_in;
			`OFF_AUX_IN:     rd_mux[WD-1:0] = d_in;
			`OFF_IRQ_EN:     rd_mux[1:0] = irq_en_q;
			default:         rd_ok = 1'b0;
		endcase
	end

	// Read channel: one cycle to the answer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers.

	logic [WC-1:0] c_oe_d;
	logic [WD-1:0] d_oe_d;
	logic [WC-1:0] c_o_d;
	logic [WD-1:0] d_o_d;
	always_comb begin
		for (int i = 0; i < WC; i++) begin
			c_o_d[i]  = c_out_q[i] & (c_mode_q[2*i +: 2] == MODE_PUSH_PULL);
			c_oe_d[i] = ((c_mode_q[2*i +: 2] == MODE_PUSH_PULL)) |
			            ((c_mode_q[2*i +: 2] == MODE_OPEN_DRAIN) & ~c_out_q[i]);
		end
		for (int j = 0; j < WD; j++) begin
			d_o_d[j]  = d_out_q[j] & (d_mode_q[2*j +: 2] == MODE_PUSH_PULL);
			d_oe_d[j] = ((d_mode_q[2*j +: 2] == MODE_PUSH_PULL)) |
			            ((d_mode_q[2*j +: 2] == MODE_OPEN_DRAIN) & ~d_out_q[j]);
		end
	end

	// Wide ports behave as quasi-bidirectional: drive low for a zero, released otherwise, pulled up only where enabled.
	// Falling edge on any pin of a wide port whose interrupt is enabled.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_wide_port_o   <= '0;
			first_wide_port_oe  <= '0;
			first_wide_port_pu  <= '0;
			second_wide_port_o  <= '0;
			second_wide_port_oe <= '0;
			second_wide_port_pu <= '0;
			drive_port_o        <= '0;
			drive_port_oe       <= '0;
			auxiliary_port_o    <= '0;
			auxiliary_port_oe   <= '0;
			a_prev_q            <= '1;
			b_prev_q            <= '1;
			first_port_irq      <= 1'b0;
			second_port_irq     <= 1'b0;
		end else begin
			first_wide_port_o   <= '0;
			first_wide_port_oe  <= ~a_out_q[WA-1:0];
			first_wide_port_pu  <= a_pu_q[WA-1:0];
			second_wide_port_o  <= '0;
			second_wide_port_oe <= ~b_out_q[WB-1:0];
			second_wide_port_pu <= b_pu_q[WB-1:0];
			drive_port_o        <= c_o_d;
			drive_port_oe       <= c_oe_d;
			auxiliary_port_o    <= d_o_d;
			auxiliary_port_oe   <= d_oe_d;
			a_prev_q            <= a_in;
			b_prev_q            <= b_in;
			first_port_irq      <= irq_en_q[`IRQ_EN_A_BIT] & |(a_prev_q & ~a_in);
			second_port_irq     <= irq_en_q[`IRQ_EN_B_BIT] & |(b_prev_q & ~b_in);
		end
	end
endmodule // gpio_ports
`default_nettype wire

// ==== sim/pin_model.sv ====
/* Board model of one port's pins.
   Assumes the bench supplies the level that the board drives. */
`timescale 1ns/1ns
`default_nettype none
module pin_model #(parameter int W = 8) (
	input	wire logic [W-1:0]	o,
	input	wire logic [W-1:0]	oe,
	input	wire logic [W-1:0]	pu,
	input	wire logic [W-1:0]	ext,
	output	var logic [W-1:0]	pin
);
	// A driven pin follows the block; a released one follows the board or its pull-up.
	assign pin = (oe & o) | (~oe & (ext | pu));
endmodule // pin_model
`default_nettype wire

// ==== sim/gpio_ports_sva.sv ====
/* Bus and pin checks for the GPIO block.
   Assumes it is bound to gpio_ports and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module gpio_ports_sva #(
	parameter int WA = 8,
	parameter int WC = 6
) (
	input	wire logic		aclk,
	input	wire logic		aresetn,
	input	wire logic		s_axi_awvalid,
	input	wire logic		s_axi_awready,
	input	wire logic		s_axi_wvalid,
	input	wire logic		s_axi_wready,
	input	wire logic		s_axi_bvalid,
	input	wire logic		s_axi_arvalid,
	input	wire logic		s_axi_arready,
	input	wire logic		s_axi_rvalid,
	input	wire logic		s_axi_rready,
	input	wire logic [31:0]	s_axi_rdata,
	input	wire logic [WA-1:0]	first_wide_port_i,
	input	wire logic [WA-1:0]	first_wide_port_o,
	input	wire logic [WA-1:0]	first_wide_port_oe,
	input	wire logic [WC-1:0]	drive_port_oe,
	input	wire logic		first_port_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken at one edge.
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken.
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	a_wide_only_low: assert property (first_wide_port_o == '0)
		else $error("wide pin driven high");
	a_wide_oe_reset: assert property ($rose(aresetn) |=> (first_wide_port_oe == '0) [*2])
		else $error("wide latch not ones after reset");
	a_drive_mode_reset: assert property ($rose(aresetn) |=> (drive_port_oe == '0) [*2])
		else $error("drive pins not inputs after reset");
	a_irq_has_cause: assert property (first_port_irq |-> ~&$past(first_wide_port_i, 2)
		|| ~&$past(first_wide_port_i, 3) || ~&$past(first_wide_port_i, 4))
		else $error("interrupt without a low pin");
endmodule // gpio_ports_sva
`default_nettype wire

// ==== sim/tb_top.sv ====
/* Self-checking bench for the GPIO block.
   Assumes the design files and the pin model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic		aclk = 1'b0;
	logic		aresetn = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, e;
	logic [31:0]	s_axi_wdata = 32'h0, rnd = 32'h000117d9;
	logic [3:0]	s_axi_wstrb = 4'h3;
	logic		s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]	s_axi_bresp, s_axi_rresp;
	wire logic [31:0]	s_axi_rdata;
	wire logic [7:0]	first_wide_port_i, first_wide_port_o, first_wide_port_oe, first_wide_port_pu;
	wire logic [7:0]	second_wide_port_i, second_wide_port_o, second_wide_port_oe, second_wide_port_pu;
	wire logic [5:0]	drive_port_i, drive_port_o, drive_port_oe;
	wire logic [4:0]	auxiliary_port_i, auxiliary_port_o, auxiliary_port_oe;
	wire logic	first_port_irq, second_port_irq;
	logic [7:0]	ext_a = 8'hff, ext_b = 8'hff;
	logic [5:0]	ext_c = 6'h3f;
	logic [4:0]	ext_d = 5'h1f;
	logic [33:0]	exp_q[$];
	logic [7:0]	rv[13] = '{8'hff, 8'hff, 8'h3d, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hff, 8'hff, 8'h3f, 8'h1f, 8'h00};
	int		bad_count = 0, n_checks = 0, irq_a = 0, irq_b = 0;

	gpio_ports dut (.*);
	pin_model #(.W(8)) pa (.o(first_wide_port_o), .oe(first_wide_port_oe),
		.pu(first_wide_port_pu), .ext(ext_a), .pin(first_wide_port_i));
	pin_model #(.W(8)) pb (.o(second_wide_port_o), .oe(second_wide_port_oe),
		.pu(second_wide_port_pu), .ext(ext_b), .pin(second_wide_port_i));
	pin_model #(.W(6)) pc (.o(drive_port_o), .oe(drive_port_oe), .pu(6'h00),
		.ext(ext_c), .pin(drive_port_i));
	pin_model #(.W(5)) pd (.o(auxiliary_port_o), .oe(auxiliary_port_oe), .pu(5'h00),
		.ext(ext_d), .pin(auxiliary_port_i));

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 40 ns period.
	always #20 aclk = ~aclk;

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [33:0] x, input logic [33:0] g);
		n_checks++;
		if (x !== g) begin
			bad_count++;
			$display("BAD at %0t exp %h got %h", $time, x, g);
		end
	endtask

	// Offers address and data together and releases each when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00,
		input logic [3:0] s = 4'h3);
		@(posedge aclk);
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
		join
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	// Reads with one cycle of stall before accepting the data.
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
		@(posedge aclk);
		exp_q.push_back({r, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Compares every bus answer with the oldest note; counts interrupt pulses.
	always @(posedge aclk) begin
		irq_a <= irq_a + int'(first_port_irq);
		irq_b <= irq_b + int'(second_port_irq);
		if (s_axi_bvalid && s_axi_bready)
			chk(exp_q.pop_front(), {s_axi_bresp, 32'h0});
		else if (s_axi_rvalid && s_axi_rready)
			chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rresp != 2'b00 ? 32'h0 : s_axi_rdata});
	end

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		complete_run();
	end

	// Main sequence of tests.
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 13; i++)
			rd(8'(4 * i), rv[i]);
		rd(8'h40, 8'h00, 2'b10);
		wr(8'h20, 32'h0, 2'b10);
		// A write with every strobe off answers OKAY and leaves the latch alone.
		wr(8'h08, 32'h0, 2'b00, 4'h0);
		rd(8'h08, 8'h3d);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			rnd = nx(rnd);
			e = i[0] ? 8'h14 : 8'h10;
			wr(e, rnd);
			rd(e, rnd[7:0]);
			chk({26'h0, rnd[7:0]}, {26'h0, i[0] ? second_wide_port_pu : first_wide_port_pu});
		end
		$display("test pull-ups done");
		ext_c <= 6'h3e;
		ext_d <= 5'h1e;
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 4; m++) begin
				wr(8'h08 + 8'(4 * p), 32'h15);
				wr(8'h18 + 8'(4 * p), {20'h0, {6{m[1:0]}}});
				e = (m == 2) ? 8'h15 : (m == 1) ? 8'h14 : 8'h3e;
				repeat (4) @(posedge aclk);
				rd(8'h28 + 8'(4 * p), p ? e & 8'h1f : e);
			end
		$display("test pin modes done");
		wr(8'h30, 32'h1);
		wr(8'h00, 32'hfe);
		wr(8'h04, 32'hfe);
		repeat (8) @(posedge aclk);
		chk(34'h1, 34'(irq_a));
		chk(34'h0, 34'(irq_b));
		wr(8'h30, 32'h2);
		wr(8'h04, 32'hff);
		wr(8'h04, 32'h7f);
		repeat (8) @(posedge aclk);
		chk(34'h1, 34'(irq_b));
		rd(8'h24, 8'h7f);
		rd(8'h00, 8'hfe);
		// Pull-ups off, then the board pulls one released pin low.
		wr(8'h14, 32'h0);
		ext_b <= 8'hbf;
		repeat (8) @(posedge aclk);
		chk(34'h2, 34'(irq_b));
		rd(8'h24, 8'h3f);
		$display("test interrupts done");
		// A second reset in mid-run must reload the first wide, drive and auxiliary latches.
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h00, 8'hff);
		rd(8'h08, 8'h3d);
		rd(8'h0c, 8'h1f);
		$display("test second reset done");
		complete_run();
	end
endmodule // tb_top

bind gpio_ports gpio_ports_sva #(.WA(WA), .WC(WC)) u_sva (.*);
`default_nettype wire
